// ==== hw/framer_err_pkg.sv ====
/*
  shared constants for the framer error count and insert control block:
  register indices, bit positions, reset values, framing patterns.
  assumes a 32-bit apb slave where byte address = 4 * register index.
*/
package framer_err_pkg;
  // register indices, byte address is index * 4
  localparam logic [7:0] IDX_CTRL_ONE   = 8'h10;
  localparam logic [7:0] IDX_CTRL_TWO   = 8'h11;
  localparam logic [7:0] IDX_INSERT     = 8'h12;
  localparam logic [7:0] IDX_LINE_CFG   = 8'h14;
  localparam logic [7:0] IDX_STATUS     = 8'h15;
  // reset values
  localparam logic [7:0] RST_CTRL_ONE   = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO   = 8'h00;
  localparam logic [7:0] RST_INSERT     = 8'h00;
  localparam logic [7:0] RST_LINE_CFG   = 8'h00;
  // control one fields
  localparam int B_LINE_STD   = 0;
  localparam int B_CBIT_EN    = 1;
  // control two fields
  localparam int B_SRC_LO     = 1;
  localparam int B_OOF_COUNT  = 3;
  localparam int B_AUTO_DEF   = 4;
  localparam int B_FORCE_FEBE = 5;
  localparam int B_RESYNC     = 7;
  localparam logic [7:0] MASK_CTRL_TWO = 8'hbf; // bit 6 not implemented
  // error insert control fields
  localparam int B_BPV        = 0;
  localparam int B_EXZ        = 1;
  localparam int B_PPAR       = 2;
  localparam int B_CPPAR      = 3;
  localparam int B_FRAME      = 4;
  localparam int B_TYPE_LO    = 5;
  localparam int B_MANUAL     = 7;
  // line config field
  localparam int B_BINARY     = 0;
  // frame error counter source codes
  localparam logic [1:0] SRC_OOF    = 2'h0;
  localparam logic [1:0] SRC_BOTH   = 2'h1;
  localparam logic [1:0] SRC_FONLY  = 2'h2;
  localparam logic [1:0] SRC_MONLY  = 2'h3;
  // far-end block error codes
  localparam logic [2:0] FEBE_NULL   = 3'h7;
  localparam logic [2:0] FEBE_ACTIVE = 3'h0;
  // e3 alignment words
  localparam logic [9:0] FAS_NORMAL  = 10'h3d0;
  localparam logic [9:0] FAS_ONE_BIT = 10'h3f0;
  localparam logic [9:0] FAS_INVERT  = 10'h02f;
  // framing error burst lengths in frames
  localparam logic [2:0] BURST_ONE    = 3'h1;
  localparam logic [2:0] BURST_F_DS3  = 3'h4;
  localparam logic [2:0] BURST_M_DS3  = 3'h3;
  localparam logic [2:0] BURST_E3     = 3'h4;
endpackage

// ==== hw/framer_err_ctrl.sv ====
/*
  framer error count qualifying, far-end block error coding, receive
  resync and transmit error insertion for one ds3/e3 channel.
  assumes the formatter and receive framer share clk and give one-cycle
  pulses on clk; the manual insert pin is asynchronous.
*/
// Functional notes
// - ds3 counter source: oof, f+m, f, m
// - e3 counter source: oof, fas bits, words
// - oof gating of overhead counters by enable
// - auto defeat only in c-bit parity ds3
// - auto report zeroes subframe four c bits
// - m, f, cp errors or oof trigger report
// - defeated: setting 0 gives 111, 1 000
// - resync bit rising edge resyncs once
// - bpv at next three ones, not binary
// - excess zeros suppress next substitution, not binary
// - p parity flips both p bits, ds3
// - cp parity flips three cp bits, c-bit
// - framing errors of chosen type, next frame
// - ds3 types: f, m, four f, three m
// - e3 types: one bit, inverted, four each
// - manual pulse inserts only enabled kinds
// - mode bit picks register or pin trigger
// - line standard: 0 e3, 1 ds3
// - c-bit enable: 0 m23, 1 c-bit parity
`timescale 1ns/1ps
`default_nettype none
module framer_err_ctrl #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // manual insert pin, asynchronous
  input  wire logic              manual_error_insert_input,
  // receive framer events
  input  wire logic              rx_oof,
  input  wire logic              rx_oof_start,
  input  wire logic              rx_f_bit_error,
  input  wire logic              rx_m_bit_error,
  input  wire logic              rx_fas_bit_error,
  input  wire logic              rx_fas_word_error,
  input  wire logic              rx_p_parity_error,
  input  wire logic              rx_cp_parity_error,
  input  wire logic              rx_febe_seen,
  // transmit formatter timing
  input  wire logic              tx_frame_start,
  input  wire logic              tx_three_ones,
  input  wire logic              tx_sub_chance,
  // counter advance pulses
  output logic                   frame_error_count_inc,
  output logic                   p_parity_count_inc,
  output logic                   cp_parity_count_inc,
  output logic                   febe_count_inc,
  // receive framer control
  output logic                   rx_resync,
  // transmit insertion controls
  output logic [2:0]             tx_febe_code,
  output logic                   tx_bpv_insert,
  output logic                   tx_sub_suppress,
  output logic                   tx_p_invert,
  output logic                   tx_cp_invert,
  output logic                   tx_f_invert,
  output logic                   tx_m_invert,
  output logic [9:0]             tx_fas_word
);

  // refuse widths without upper address bits
  if (ADDR_W < 11 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must lie between 11 and 32");
  end

  // registers
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [7:0] insert_reg;
  logic [7:0] line_cfg_reg;
  logic [7:0] insert_prev_reg;
  logic       resync_prev_reg;
  logic [1:0] pin_sync_reg;
  logic       pin_prev_reg;
  logic       pend_bpv_reg;
  logic       pend_exz_reg;
  logic       pend_p_reg;
  logic       pend_cp_reg;
  logic       pend_frame_reg;
  logic [1:0] frame_type_reg;
  logic [2:0] frames_left_reg;
  logic       febe_cond_reg;

  // mode decode
  wire        ds3      = ctrl_one_reg[framer_err_pkg::B_LINE_STD];
  wire        cbit     = ds3 & ctrl_one_reg[framer_err_pkg::B_CBIT_EN];
  wire        binary   = line_cfg_reg[framer_err_pkg::B_BINARY];
  wire [1:0]  src_sel  = ctrl_two_reg[framer_err_pkg::B_SRC_LO +: 2];
  wire        oof_ok   = ctrl_two_reg[framer_err_pkg::B_OOF_COUNT];
  wire        auto_def = ctrl_two_reg[framer_err_pkg::B_AUTO_DEF];
  wire        force_fe = ctrl_two_reg[framer_err_pkg::B_FORCE_FEBE];
  wire        manual   = insert_reg[framer_err_pkg::B_MANUAL];
  wire [1:0]  err_type = insert_reg[framer_err_pkg::B_TYPE_LO +: 2];

  // apb decode
  wire [7:0]  idx      = paddr[9:2];
  wire        setup    = psel & ~penable;
  wire        wr_done  = psel & penable & pready & pwrite;
  wire        hit_one  = idx == framer_err_pkg::IDX_CTRL_ONE;
  wire        hit_two  = idx == framer_err_pkg::IDX_CTRL_TWO;
  wire        hit_ins  = idx == framer_err_pkg::IDX_INSERT;
  wire        hit_line = idx == framer_err_pkg::IDX_LINE_CFG;
  wire        hit_stat = idx == framer_err_pkg::IDX_STATUS;
  wire        upper_ok = paddr[ADDR_W-1:10] == '0;
  wire        mapped   = upper_ok &
                         (hit_one | hit_two | hit_ins | hit_line | hit_stat);
  wire [7:0]  wbyte    = pwdata[7:0];
  wire [7:0]  status   = {frames_left_reg, febe_cond_reg, pend_frame_reg,
                          pend_cp_reg, pend_p_reg, pend_exz_reg | pend_bpv_reg};
  logic [7:0] rd_sel;

  // read mux, unmapped reads give zero
  always_comb begin
    rd_sel = 8'h00;
    if (!upper_ok)
      rd_sel = 8'h00;
    else if (hit_one)
      rd_sel = ctrl_one_reg;
    else if (hit_two)
      rd_sel = ctrl_two_reg;
    else if (hit_ins)
      rd_sel = insert_reg;
    else if (hit_line)
      rd_sel = line_cfg_reg;
    else if (hit_stat)
      rd_sel = status;
  end

  // no wait state: ready comes one cycle after setup
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite)
        prdata <= {24'h00_0000, rd_sel};
    end
  end

  // software registers, status index is read only
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_one_reg <= framer_err_pkg::RST_CTRL_ONE;
      ctrl_two_reg <= framer_err_pkg::RST_CTRL_TWO;
      insert_reg   <= framer_err_pkg::RST_INSERT;
      line_cfg_reg <= framer_err_pkg::RST_LINE_CFG;
    end else if (ce && wr_done && upper_ok) begin
      if (hit_one)
        ctrl_one_reg <= wbyte;
      else if (hit_two)
        ctrl_two_reg <= wbyte & framer_err_pkg::MASK_CTRL_TWO;
      else if (hit_ins)
        insert_reg <= wbyte;
      else if (hit_line)
        line_cfg_reg <= {7'h00, wbyte[framer_err_pkg::B_BINARY]};
    end
  end

  // pin synchroniser; only the second stage feeds the edge detect
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_sync_reg    <= 2'h0;
      pin_prev_reg    <= 1'b0;
      insert_prev_reg <= 8'h00;
      resync_prev_reg <= 1'b0;
    end else if (ce) begin
      pin_sync_reg    <= {pin_sync_reg[0], manual_error_insert_input};
      pin_prev_reg    <= pin_sync_reg[1];
      insert_prev_reg <= insert_reg;
      resync_prev_reg <= ctrl_two_reg[framer_err_pkg::B_RESYNC];
    end
  end

  // trigger selection between register edges and pin edges
  wire        pin_rise = pin_sync_reg[1] & ~pin_prev_reg;
  wire [4:0]  bit_rise = insert_reg[4:0] & ~insert_prev_reg[4:0];
  wire [4:0]  trig     = manual ? (insert_reg[4:0] & {5{pin_rise}})
                                : bit_rise;
  // kinds that have no meaning in the current mode are dropped
  wire arm_bpv   = trig[framer_err_pkg::B_BPV] & ~binary;
  wire arm_exz   = trig[framer_err_pkg::B_EXZ] & ~binary;
  wire arm_p     = trig[framer_err_pkg::B_PPAR] & ds3;
  wire arm_cp    = trig[framer_err_pkg::B_CPPAR] & cbit;
  wire arm_frame = trig[framer_err_pkg::B_FRAME];

  // burst length for the chosen framing error type
  function automatic logic [2:0] burst_len(input logic is_ds3,
                                           input logic [1:0] kind);
    logic [2:0] n;
    n = framer_err_pkg::BURST_ONE;
    if (kind[1])
      n = !is_ds3 ? framer_err_pkg::BURST_E3
        : kind[0] ? framer_err_pkg::BURST_M_DS3
                  : framer_err_pkg::BURST_F_DS3;
    return n;
  endfunction

  // frame start: a pending burst begins, else a running one continues
  wire [2:0]  burst_now  = pend_frame_reg ? burst_len(ds3, err_type)
                                          : frames_left_reg;
  wire [1:0]  type_now   = pend_frame_reg ? err_type : frame_type_reg;
  wire        burst_on   = tx_frame_start & (burst_now != 3'h0);
  wire [2:0]  left_next  = burst_now - 3'h1;
  wire        use_m      = ds3 & type_now[0];
  wire [9:0]  fas_bad    = type_now[0] ? framer_err_pkg::FAS_INVERT
                                       : framer_err_pkg::FAS_ONE_BIT;

  // pending insertions; a new arm wins over a same-cycle consume
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_bpv_reg   <= 1'b0;
      pend_exz_reg   <= 1'b0;
      pend_p_reg     <= 1'b0;
      pend_cp_reg    <= 1'b0;
      pend_frame_reg <= 1'b0;
    end else if (ce) begin
      pend_bpv_reg   <= arm_bpv | (pend_bpv_reg & ~tx_three_ones);
      pend_exz_reg   <= arm_exz | (pend_exz_reg & ~tx_sub_chance);
      pend_p_reg     <= arm_p | (pend_p_reg & ~tx_frame_start);
      pend_cp_reg    <= arm_cp | (pend_cp_reg & ~tx_frame_start);
      pend_frame_reg <= arm_frame | (pend_frame_reg & ~tx_frame_start);
    end
  end

  // framing burst state
  always_ff @(posedge clk) begin
    if (srst) begin
      frames_left_reg <= 3'h0;
      frame_type_reg  <= 2'h0;
    end else if (ce && burst_on) begin
      frames_left_reg <= left_next;
      frame_type_reg  <= type_now;
    end
  end

  // transmit insertion outputs; per-frame levels change at frame start
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_bpv_insert   <= 1'b0;
      tx_sub_suppress <= 1'b0;
      tx_p_invert     <= 1'b0;
      tx_cp_invert    <= 1'b0;
      tx_f_invert     <= 1'b0;
      tx_m_invert     <= 1'b0;
      tx_fas_word     <= framer_err_pkg::FAS_NORMAL;
    end else if (ce) begin
      tx_bpv_insert   <= pend_bpv_reg & tx_three_ones;
      tx_sub_suppress <= pend_exz_reg & tx_sub_chance;
      if (tx_frame_start) begin
        tx_p_invert  <= pend_p_reg;
        tx_cp_invert <= pend_cp_reg;
        tx_f_invert  <= burst_on & ds3 & ~use_m;
        tx_m_invert  <= burst_on & use_m;
        tx_fas_word  <= (burst_on & ~ds3) ? fas_bad
                                          : framer_err_pkg::FAS_NORMAL;
      end
    end
  end

  // far-end block error condition gathered over one transmit frame
  wire febe_event = rx_m_bit_error | rx_f_bit_error | rx_cp_parity_error |
                    rx_oof;
  logic [2:0] febe_next;

  // code chosen at each frame start; auto defeat only in c-bit ds3
  always_comb begin
    febe_next = framer_err_pkg::FEBE_NULL;
    if (!cbit)
      febe_next = framer_err_pkg::FEBE_NULL;
    else if (auto_def)
      febe_next = force_fe ? framer_err_pkg::FEBE_ACTIVE
                           : framer_err_pkg::FEBE_NULL;
    else if (febe_cond_reg || febe_event)
      febe_next = framer_err_pkg::FEBE_ACTIVE;
  end

  // condition sticks until the frame that reports it; event wins
  always_ff @(posedge clk) begin
    if (srst) begin
      febe_cond_reg <= 1'b0;
      tx_febe_code  <= framer_err_pkg::FEBE_NULL;
    end else if (ce) begin
      febe_cond_reg <= febe_event | (febe_cond_reg & ~tx_frame_start);
      if (tx_frame_start)
        tx_febe_code <= febe_next;
    end
  end

  // counter source select and oof gating
  wire        count_gate = oof_ok | ~rx_oof;
  logic       fe_hit;

  always_comb begin
    fe_hit = 1'b0;
    if (src_sel == framer_err_pkg::SRC_OOF)
      fe_hit = rx_oof_start;
    else if (ds3 && src_sel == framer_err_pkg::SRC_BOTH)
      fe_hit = count_gate & (rx_f_bit_error | rx_m_bit_error);
    else if (ds3 && src_sel == framer_err_pkg::SRC_FONLY)
      fe_hit = count_gate & rx_f_bit_error;
    else if (ds3)
      fe_hit = count_gate & rx_m_bit_error;
    else if (src_sel == framer_err_pkg::SRC_BOTH)
      fe_hit = count_gate & rx_fas_bit_error;
    else if (src_sel == framer_err_pkg::SRC_FONLY)
      fe_hit = count_gate & rx_fas_word_error;
  end

  // counter pulses and resync, all registered
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_error_count_inc <= 1'b0;
      p_parity_count_inc    <= 1'b0;
      cp_parity_count_inc   <= 1'b0;
      febe_count_inc        <= 1'b0;
      rx_resync             <= 1'b0;
    end else if (ce) begin
      frame_error_count_inc <= fe_hit;
      p_parity_count_inc    <= count_gate & ds3 & rx_p_parity_error;
      cp_parity_count_inc   <= count_gate & cbit & rx_cp_parity_error;
      febe_count_inc        <= count_gate & cbit & rx_febe_seen;
      rx_resync             <= ctrl_two_reg[framer_err_pkg::B_RESYNC] &
                               ~resync_prev_reg;
    end
  end

endmodule
`default_nettype wire

// ==== tb/framer_err_ctrl_assertions.sv ====
/*
  port-level checks for the error control block, bound to its top.
  assumes ce is high during bus use and addresses are word aligned.
*/
`timescale 1ns/1ps
`default_nettype none
module framer_err_ctrl_assertions #(
  parameter int ADDR_W = 12
) (
  // clock, reset
  input wire logic              clk,
  input wire logic              srst,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // receive events and frame timing
  input wire logic              rx_oof,
  input wire logic              rx_oof_start,
  input wire logic              rx_f_bit_error,
  input wire logic              rx_m_bit_error,
  input wire logic              rx_cp_parity_error,
  input wire logic              tx_frame_start,
  // design outputs
  input wire logic              frame_error_count_inc,
  input wire logic              p_parity_count_inc,
  input wire logic              cp_parity_count_inc,
  input wire logic              febe_count_inc,
  input wire logic              rx_resync,
  input wire logic [2:0]        tx_febe_code
);
  logic [7:0] one_q;
  logic [7:0] two_q;
  // decode of the watched bus, shadow follows the write edge
  wire [7:0] idx    = paddr[9:2];
  wire       wr_hit = psel && penable && pready && pwrite;
  wire       mapped = paddr[ADDR_W-1:10] == '0 && idx inside {
    framer_err_pkg::IDX_CTRL_ONE, framer_err_pkg::IDX_CTRL_TWO,
    framer_err_pkg::IDX_INSERT, framer_err_pkg::IDX_LINE_CFG,
    framer_err_pkg::IDX_STATUS};
  wire       cbm    = one_q[0] && one_q[1];
  wire [1:0] src    = two_q[2:1];
  // shadow only the two control words the checks depend on
  always_ff @(posedge clk) begin
    if (srst) begin
      one_q <= 8'h00;
      two_q <= 8'h00;
    end else if (wr_hit && idx == framer_err_pkg::IDX_CTRL_ONE) begin
      one_q <= pwdata[7:0];
    end else if (wr_hit && idx == framer_err_pkg::IDX_CTRL_TWO) begin
      two_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // request steps
  sequence s_forced;
    tx_frame_start && cbm && two_q[4];
  endsequence
  sequence s_resync_req;
    wr_hit && idx == framer_err_pkg::IDX_CTRL_TWO && pwdata[7] && !two_q[7];
  endsequence
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no access answer after setup");
  AST_SLVERR: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not fit address");
  AST_SRC_OOF: assert property (
    src == framer_err_pkg::SRC_OOF |=>
    frame_error_count_inc == $past(rx_oof_start))
    else $error("oof source count wrong");
  AST_DS3_MONLY: assert property (
    one_q[0] && src == framer_err_pkg::SRC_MONLY && (two_q[3] || !rx_oof)
    |=> frame_error_count_inc == $past(rx_m_bit_error))
    else $error("m-bit only count wrong");
  AST_E3_ILLEGAL: assert property (
    !one_q[0] && src == framer_err_pkg::SRC_MONLY |=> !frame_error_count_inc)
    else $error("illegal e3 source counted");
  AST_OOF_GATE: assert property (
    !two_q[3] && rx_oof && src != framer_err_pkg::SRC_OOF |=>
    !(frame_error_count_inc || p_parity_count_inc ||
      cp_parity_count_inc || febe_count_inc))
    else $error("count advanced while out of frame");
  AST_FEBE_MODE: assert property (
    tx_frame_start && !cbm |=> tx_febe_code == framer_err_pkg::FEBE_NULL)
    else $error("febe code outside c-bit mode");
  AST_FEBE_FORCED: assert property (
    s_forced |=> tx_febe_code == ($past(two_q[5]) ?
    framer_err_pkg::FEBE_ACTIVE : framer_err_pkg::FEBE_NULL))
    else $error("forced febe code wrong");
  AST_FEBE_AUTO: assert property (
    tx_frame_start && cbm && !two_q[4] && (rx_m_bit_error ||
    rx_f_bit_error || rx_cp_parity_error || rx_oof) |=>
    tx_febe_code == framer_err_pkg::FEBE_ACTIVE)
    else $error("automatic febe not reported");
  AST_RESYNC: assert property (s_resync_req |-> ##2 rx_resync)
    else $error("resync pulse missing");
  AST_RESYNC_ONE: assert property (rx_resync |=> !rx_resync)
    else $error("resync pulse too long");
  AST_CP_COUNT: assert property (
    cbm && rx_cp_parity_error && (two_q[3] || !rx_oof) |=>
    cp_parity_count_inc)
    else $error("cp parity count missing");
endmodule
bind framer_err_ctrl framer_err_ctrl_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .rx_oof, .rx_oof_start, .rx_f_bit_error, .rx_m_bit_error,
  .rx_cp_parity_error, .tx_frame_start, .frame_error_count_inc,
  .p_parity_count_inc, .cp_parity_count_inc, .febe_count_inc, .rx_resync,
  .tx_febe_code);
`default_nettype wire

// ==== tb/tx_timing_model.sv ====
/*
  transmit formatter timing seen by the block: one frame start, one
  three-ones run and one substitution chance in every frame.
  assumes the shared clock and synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tx_timing_model #(
  parameter int FRAME = 40
) (
  // clock, reset
  input  wire logic clk,
  input  wire logic srst,
  // formatter pulses
  output logic      tx_frame_start,
  output logic      tx_three_ones,
  output logic      tx_sub_chance
);
  int phase;
  // pulses at fixed places so bursts line up with frame counts
  always_ff @(posedge clk) begin
    if (srst) begin
      phase          <= 0;
      tx_frame_start <= 1'b0;
      tx_three_ones  <= 1'b0;
      tx_sub_chance  <= 1'b0;
    end else begin
      phase          <= (phase == FRAME - 1) ? 0 : phase + 1;
      tx_frame_start <= (phase == 0);
      tx_three_ones  <= (phase == FRAME / 4);
      tx_sub_chance  <= (phase == FRAME / 2);
    end
  end
endmodule
`default_nettype wire

// ==== tb/framer_error_count_insert_tb.sv ====
/*
  self-checking bench: registers, febe coding, resync, insertion kinds,
  manual pin and random receive events.
  assumes the timing model and the bound checker beside the block.
*/
`timescale 1ns/1ps
`default_nettype none
module framer_error_count_insert_tb;
  logic        clk, srst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [10:0] rx_bus;
  logic        manual_error_insert_input, fs_d;
  logic        tx_frame_start, tx_three_ones, tx_sub_chance;
  logic        frame_error_count_inc, p_parity_count_inc, rx_resync;
  logic        cp_parity_count_inc, febe_count_inc;
  logic        tx_bpv_insert, tx_sub_suppress, tx_p_invert, tx_cp_invert;
  logic        tx_f_invert, tx_m_invert;
  logic [2:0]  tx_febe_code;
  logic [9:0]  tx_fas_word;
  int          fail_count, checks_done;
  int          cnt [9];
  int          base [9];
  framer_err_ctrl uut (.clk, .srst, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .manual_error_insert_input,
    .rx_oof(rx_bus[0]), .rx_oof_start(rx_bus[1]),
    .rx_f_bit_error(rx_bus[2]), .rx_m_bit_error(rx_bus[3]),
    .rx_fas_bit_error(rx_bus[4]), .rx_fas_word_error(rx_bus[5]),
    .rx_p_parity_error(rx_bus[6]), .rx_cp_parity_error(rx_bus[7]),
    .rx_febe_seen(rx_bus[8]), .tx_frame_start, .tx_three_ones,
    .tx_sub_chance, .frame_error_count_inc, .p_parity_count_inc,
    .cp_parity_count_inc, .febe_count_inc, .rx_resync, .tx_febe_code,
    .tx_bpv_insert, .tx_sub_suppress, .tx_p_invert, .tx_cp_invert,
    .tx_f_invert, .tx_m_invert, .tx_fas_word);
  tx_timing_model #(.FRAME(40)) fmt (.clk, .srst, .tx_frame_start,
    .tx_three_ones, .tx_sub_chance);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // per-frame levels sampled once, pulses every cycle
  always @(posedge clk) begin
    fs_d <= tx_frame_start;
    cnt[0] += fs_d & tx_f_invert;
    cnt[1] += fs_d & tx_m_invert;
    cnt[2] += fs_d & tx_p_invert;
    cnt[3] += fs_d & tx_cp_invert;
    cnt[4] += fs_d & (tx_fas_word === framer_err_pkg::FAS_ONE_BIT);
    cnt[5] += fs_d & (tx_fas_word === framer_err_pkg::FAS_INVERT);
    cnt[6] += tx_bpv_insert;
    cnt[7] += tx_sub_suppress;
    cnt[8] += rx_resync;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // frames of a burst kind: one, four, or three for ds3 m-bit runs
  function automatic int burst(input bit ds3, input int t, input bit sec);
    if (sec != t[0]) return 0;
    if (t < 2) return 1;
    return (ds3 && sec) ? 3 : 4;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] i, input logic [31:0] e, input bit x);
    apb(1'b0, i, 8'h00);
    chk(rd, e);
    chk(err, x);
  endtask
  task automatic snap();
    @(negedge clk);
    foreach (cnt[k]) base[k] = cnt[k];
  endtask
  task automatic got(input int k, input int e);
    chk(cnt[k] - base[k], e);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk);
      while (tx_frame_start !== 1'b1) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic ins(input logic [7:0] v, input int nf);
    apb(1'b1, framer_err_pkg::IDX_INSERT, v & 8'h80);
    snap();
    apb(1'b1, framer_err_pkg::IDX_INSERT, v);
    frames(nf);
  endtask
  task automatic fr_loop(input bit ds3);
    for (int t = 0; t < 4; t++) begin
      ins(8'h10 | (t[7:0] << 5), 6);
      got(ds3 ? 0 : 4, burst(ds3, t, 1'b0));
      got(ds3 ? 1 : 5, burst(ds3, t, 1'b1));
    end
  endtask
  initial begin
    #(25 * 30000);
    fail_count++;
    stop_test();
  end
  initial begin
    {ce, srst, psel, penable, pwrite, manual_error_insert_input} = 6'h30;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_bus = 11'h000;
    seed = 32'h3e;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rchk(framer_err_pkg::IDX_CTRL_ONE, 32'h0, 1'b0);
    rchk(framer_err_pkg::IDX_CTRL_TWO, 32'h0, 1'b0);
    rchk(framer_err_pkg::IDX_INSERT, 32'h0, 1'b0);
    rchk(8'h13, 32'h0, 1'b1);
    snap();
    apb(1'b1, framer_err_pkg::IDX_CTRL_TWO, 8'hff);
    rchk(framer_err_pkg::IDX_CTRL_TWO, {24'h0, 8'hbf}, 1'b0);
    apb(1'b1, framer_err_pkg::IDX_CTRL_TWO, 8'hbf);
    apb(1'b1, framer_err_pkg::IDX_CTRL_TWO, 8'h00);
    apb(1'b1, framer_err_pkg::IDX_CTRL_TWO, 8'h80);
    frames(1);
    got(8, 2);
    apb(1'b1, framer_err_pkg::IDX_CTRL_TWO, 8'h30);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, framer_err_pkg::IDX_CTRL_ONE, m[7:0]);
      frames(2);
      chk(tx_febe_code, m == 3 ? 3'h0 : 3'h7);
    end
    apb(1'b1, framer_err_pkg::IDX_CTRL_TWO, 8'h00);
    frames(2);
    chk(tx_febe_code, framer_err_pkg::FEBE_NULL);
    // an event while ce is low must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    rx_bus <= 11'h008;
    @(posedge clk);
    rx_bus <= 11'h000;
    @(posedge clk);
    ce <= 1'b1;
    frames(1);
    chk(tx_febe_code, framer_err_pkg::FEBE_NULL);
    @(posedge clk);
    rx_bus <= 11'h008;
    @(posedge clk);
    rx_bus <= 11'h000;
    frames(1);
    chk(tx_febe_code, framer_err_pkg::FEBE_ACTIVE);
    ins(8'h04, 2);
    got(2, 1);
    snap();
    apb(1'b1, framer_err_pkg::IDX_INSERT, 8'h04);
    frames(2);
    got(2, 0);
    ins(8'h08, 2);
    got(3, 1);
    ins(8'h01, 2);
    got(6, 1);
    ins(8'h02, 2);
    got(7, 1);
    fr_loop(1'b1);
    ins(8'h85, 2);
    got(2, 0);
    for (int k = 0; k < 2; k++) begin
      snap();
      @(posedge clk);
      manual_error_insert_input <= 1'b1;
      frames(2);
      got(2, 1);
      got(6, 1);
      got(3, 0);
      @(posedge clk);
      manual_error_insert_input <= 1'b0;
    end
    apb(1'b1, framer_err_pkg::IDX_LINE_CFG, 8'h01);
    ins(8'h03, 2);
    got(6, 0);
    got(7, 0);
    apb(1'b1, framer_err_pkg::IDX_LINE_CFG, 8'h00);
    apb(1'b1, framer_err_pkg::IDX_CTRL_ONE, 8'h01);
    ins(8'h0c, 2);
    got(3, 0);
    apb(1'b1, framer_err_pkg::IDX_CTRL_ONE, 8'h00);
    ins(8'h0c, 2);
    got(2, 0);
    fr_loop(1'b0);
    // random receive events, mode and source choices checked by the binder
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      apb(1'b1, framer_err_pkg::IDX_CTRL_ONE, {6'h0, seed[1:0]});
      apb(1'b1, framer_err_pkg::IDX_CTRL_TWO, seed[9:2] & 8'h3e);
      repeat (40) begin
        @(posedge clk);
        seed = xs(seed);
        rx_bus <= {seed[10:1], &seed[2:0]};
      end
      @(posedge clk);
      rx_bus <= 11'h000;
    end
    stop_test();
  end
endmodule
`default_nettype wire
